/* inc/ttm_pkg.sv */
// ==========================================================================
// Shared constants and types for the triple timer block
// ==========================================================================
package ttm_pkg;

  // ========================================================================
  // Register indices (byte address is four times the index)
  // ========================================================================
  localparam int IDX_W = 4;                              // Index field width
  localparam logic [IDX_W-1:0] IDX_MODE_A = 4'h8;        // timer_a_mode
  localparam logic [IDX_W-1:0] IDX_MODE_B = 4'h9;        // timer_b_mode
  localparam logic [IDX_W-1:0] IDX_DIG_B_LO = 4'hA;      // B count/reload low
  localparam logic [IDX_W-1:0] IDX_DIG_B_HI = 4'hB;      // B count/reload high
  localparam logic [IDX_W-1:0] IDX_MODE_C = 4'hD;        // timer_c_mode
  localparam logic [IDX_W-1:0] IDX_DIG_C_LO = 4'hE;      // C count/reload low
  localparam logic [IDX_W-1:0] IDX_DIG_C_HI = 4'hF;      // C count/reload high
  localparam int IDX_LSB = 2;                            // Word aligned index

  // ========================================================================
  // Field layout and reset values
  // ========================================================================
  localparam int MODE_SEL_BIT = 3;                       // Time base / auto reload
  localparam logic [3:0] MODE_RST = 4'h0;                // Mode reset value
  localparam logic [7:0] RELOAD_RST = 8'h00;             // Load register reset
  localparam logic [7:0] COUNT_RST = 8'h00;              // Counter reset
  localparam logic [7:0] COUNT_TOP = 8'hFF;              // Last count before wrap
  localparam logic [2:0] CODE_B_EXT = 3'h7;              // Timer B external event
  localparam logic [2:0] CODE_TB_RSV = 3'h5;             // Reserved time base code
  localparam logic [1:0] CODE_TB_RST = 2'h3;             // Codes 110/111 upper bits

  // ========================================================================
  // Prescaler widths and timing
  // ========================================================================
  localparam int SYS_PSC_W = 11;                         // Divides up to 2048
  localparam int SUB_PSC_W = 6;                          // 64 half sub-cycles
  localparam int MODE_LAG_CYC = 2;                       // Mode write latency

  // Overflow pulses of the three timers
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } ttm_ovf_t;

endpackage : ttm_pkg

/* logic/ttm_timers.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

module ttm_timers
  import ttm_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources
  input wire logic subTick,
  input wire logic evtInN,
  // Outputs
  output ttm_pkg::ttm_ovf_t ovf,
  output logic pwmOut,
  output logic lcdPowerOff
);
  import ttm_pkg::*;

  // ========================================================================
  // Decode helpers
  // ========================================================================
  // True in the cycle where a 2^k prescaler tap rolls over
  function automatic logic tapHit(input logic [SYS_PSC_W-1:0] p, input logic [3:0] k);
    logic [SYS_PSC_W-1:0] m;
    m = ~({SYS_PSC_W{1'b1}} << k);
    return &(p | ~m);
  endfunction : tapHit

  // Eight ratio table shared by timer A interval mode, timer B and timer C
  function automatic logic [3:0] log8(input logic [2:0] code);
    logic [3:0] k;
    k = 4'hB;
    case (code)
      3'h0: k = 4'hB;
      3'h1: k = 4'hA;
      3'h2: k = 4'h9;
      3'h3: k = 4'h7;
      3'h4: k = 4'h5;
      3'h5: k = 4'h3;
      3'h6: k = 4'h2;
      default: k = 4'h1;
    endcase
    return k;
  endfunction : log8

  // ========================================================================
  // State
  // ========================================================================
  logic [3:0] modeA_reg;                   // Timer A mode, acts at once
  logic [3:0] modeBPend_reg;               // Timer B mode as written
  logic [3:0] modeB_reg;                   // Timer B mode in effect
  logic [3:0] modeCPend_reg;               // Timer C mode as written
  logic [3:0] modeC_reg;                   // Timer C mode in effect
  logic [SYS_PSC_W-1:0] sysPsc_reg;        // System prescaler
  logic [SUB_PSC_W-1:0] subPsc_reg;        // Sub prescaler, half sub-cycles
  logic [7:0] cntA_reg;                    // Timer A count
  logic [7:0] cntB_reg;                    // Timer B count
  logic [7:0] cntC_reg;                    // Timer C count
  logic [7:0] reloadB_reg;                 // Timer B load register
  logic [7:0] reloadC_reg;                 // Timer C load register
  logic [3:0] capB_reg;                    // Low digit caught on high read
  logic [3:0] capC_reg;
  logic [7:0] pwmRef_reg;                  // Duty reference taken at overflow
  logic [1:0] evtSync_reg;                 // Event input synchroniser
  logic evtLast_reg;                       // Previous synchronised level

  // ========================================================================
  // Bus decode
  // ========================================================================
  wire logic [IDX_W-1:0] idx = paddr[IDX_LSB +: IDX_W];
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic hitModeA = (idx == IDX_MODE_A);
  wire logic hitModeB = (idx == IDX_MODE_B);
  wire logic hitModeC = (idx == IDX_MODE_C);
  wire logic hitBLo = (idx == IDX_DIG_B_LO);
  wire logic hitBHi = (idx == IDX_DIG_B_HI);
  wire logic hitCLo = (idx == IDX_DIG_C_LO);
  wire logic hitCHi = (idx == IDX_DIG_C_HI);
  wire logic mapped = hitModeA || hitModeB || hitModeC || hitBLo || hitBHi || hitCLo || hitCHi;
  wire logic wrEn = access && pwrite && mapped;
  wire logic wrModeA = wrEn && hitModeA;
  wire logic wrModeB = wrEn && hitModeB;
  wire logic wrModeC = wrEn && hitModeC;
  wire logic wrBLo = wrEn && hitBLo;
  wire logic wrBHi = wrEn && hitBHi;
  wire logic wrCLo = wrEn && hitCLo;
  wire logic wrCHi = wrEn && hitCHi;
  // Reads sample in setup so prdata comes from flip-flops at access
  wire logic rdBHi = setup && !pwrite && hitBHi;
  wire logic rdCHi = setup && !pwrite && hitCHi;
  wire logic [3:0] wrDigit = pwdata[3:0];

  // Zero wait slave; mode registers read as zero
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Read data: high digit live, low digit from the capture latch
  wire logic [3:0] rdDigit = hitBHi ? cntB_reg[7:4] :
                             hitBLo ? capB_reg :
                             hitCHi ? cntC_reg[7:4] :
                             hitCLo ? capC_reg : 4'h0;

  // ========================================================================
  // Clock enables
  // ========================================================================
  wire logic timeBase = modeA_reg[MODE_SEL_BIT];
  wire logic [2:0] codeA = modeA_reg[2:0];
  wire logic subHold = timeBase && (codeA[2:1] == CODE_TB_RST);
  // Half sub-cycle taps: 64, 32, 16, 4, 1 for codes 0..4
  wire logic [3:0] subK = (codeA == 3'h0) ? 4'h6 :
                          (codeA == 3'h1) ? 4'h5 :
                          (codeA == 3'h2) ? 4'h4 :
                          (codeA == 3'h3) ? 4'h2 : 4'h0;
  wire logic [SYS_PSC_W-1:0] subWide = {{(SYS_PSC_W-SUB_PSC_W){1'b0}}, subPsc_reg};
  // Reserved code and reset codes give no timer A clock
  wire logic subOk = (codeA != CODE_TB_RSV) && !subHold;
  wire logic tickASub = subTick && subOk && tapHit(subWide, subK);
  wire logic tickASys = tapHit(sysPsc_reg, log8(codeA));
  wire logic tickA = timeBase ? tickASub : tickASys;
  wire logic [2:0] codeB = modeB_reg[2:0];
  // Timer B lacks the 1024 tap, so codes 1.. shift by one table slot
  wire logic [2:0] slotB = (codeB == 3'h0) ? 3'h0 : 3'(codeB + 3'h1);
  wire logic evtEdge = evtLast_reg && !evtSync_reg[1];                 // Falling edge
  wire logic tickB = (codeB == CODE_B_EXT) ? evtEdge :
                     tapHit(sysPsc_reg, log8(slotB));
  wire logic tickC = tapHit(sysPsc_reg, log8(modeC_reg[2:0]));
  wire logic wrapA = tickA && (cntA_reg == COUNT_TOP);
  wire logic wrapB = tickB && (cntB_reg == COUNT_TOP);
  wire logic wrapC = tickC && (cntC_reg == COUNT_TOP);
  wire logic [7:0] restartB = modeB_reg[MODE_SEL_BIT] ? reloadB_reg : COUNT_RST;
  wire logic [7:0] restartC = modeC_reg[MODE_SEL_BIT] ? reloadC_reg : COUNT_RST;

  // ========================================================================
  // Mode registers
  // ========================================================================
  // Timer A acts at once; B and C pass a pending stage first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      modeA_reg <= MODE_RST;
      modeBPend_reg <= MODE_RST;
      modeB_reg <= MODE_RST;
      modeCPend_reg <= MODE_RST;
      modeC_reg <= MODE_RST;
    end else begin
      if (wrModeA) begin
        modeA_reg <= wrDigit;
      end
      if (wrModeB) begin
        modeBPend_reg <= wrDigit;
      end
      if (wrModeC) begin
        modeCPend_reg <= wrDigit;
      end
      modeB_reg <= modeBPend_reg;
      modeC_reg <= modeCPend_reg;
    end
  end

  // ========================================================================
  // Prescalers and event synchroniser
  // ========================================================================
  // Changing the time base ratio mid-run skews one period; software avoids it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sysPsc_reg <= '0;
      subPsc_reg <= '0;
      evtSync_reg <= 2'h3;
      evtLast_reg <= 1'b1;
    end else begin
      sysPsc_reg <= sysPsc_reg + 11'h001;
      if (subHold) begin
        subPsc_reg <= '0;
      end else if (subTick) begin
        subPsc_reg <= subPsc_reg + 6'h01;
      end
      evtSync_reg <= {evtSync_reg[0], evtInN};
      evtLast_reg <= evtSync_reg[1];
    end
  end

  // ========================================================================
  // Load registers and capture latches
  // ========================================================================
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reloadB_reg <= RELOAD_RST;
      reloadC_reg <= RELOAD_RST;
      capB_reg <= 4'h0;
      capC_reg <= 4'h0;
      prdata <= 32'h0000_0000;
    end else begin
      if (wrBLo) begin
        reloadB_reg[3:0] <= wrDigit;
      end
      if (wrBHi) begin
        reloadB_reg[7:4] <= wrDigit;
      end
      if (wrCLo) begin
        reloadC_reg[3:0] <= wrDigit;
      end
      if (wrCHi) begin
        reloadC_reg[7:4] <= wrDigit;
      end
      if (rdBHi) begin
        capB_reg <= cntB_reg[3:0];
      end
      if (rdCHi) begin
        capC_reg <= cntC_reg[3:0];
      end
      if (setup) begin
        prdata <= {28'h0000000, rdDigit};
      end
    end
  end

  // ========================================================================
  // Counters
  // ========================================================================
  // A high digit write beats a count in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntA_reg <= COUNT_RST;
      cntB_reg <= COUNT_RST;
      cntC_reg <= COUNT_RST;
      ovf <= '0;
      pwmRef_reg <= RELOAD_RST;
      pwmOut <= 1'b0;
      lcdPowerOff <= 1'b0;
    end else begin
      if (subHold) begin
        cntA_reg <= COUNT_RST;
      end else if (tickA) begin
        cntA_reg <= cntA_reg + 8'h01;
      end
      if (wrBHi) begin
        cntB_reg <= {wrDigit, reloadB_reg[3:0]};
      end else if (wrapB) begin
        cntB_reg <= restartB;
      end else if (tickB) begin
        cntB_reg <= cntB_reg + 8'h01;
      end
      if (wrCHi) begin
        cntC_reg <= {wrDigit, reloadC_reg[3:0]};
      end else if (wrapC) begin
        cntC_reg <= restartC;
      end else if (tickC) begin
        cntC_reg <= cntC_reg + 8'h01;
      end
      ovf <= '{a: wrapA, b: wrapB, c: wrapC};
      if (wrapC) begin
        pwmRef_reg <= reloadC_reg;
      end
      // High for counts from the reference up; the reference lags a load
      pwmOut <= (cntC_reg >= pwmRef_reg);
      lcdPowerOff <= subHold;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  sequence s_modeBWrite;
    wrModeB ##1 $stable(modeB_reg);
  endsequence

  sequence s_modeCWrite;
    wrModeC ##1 $stable(modeC_reg);
  endsequence

  a_mode_b_lag: assert property (@(posedge clk) disable iff (!nrst)
    s_modeBWrite |=> (modeB_reg == $past(pwdata[3:0], 2)))
    else $error("timer B mode did not settle two cycles after write");

  a_mode_c_lag: assert property (@(posedge clk) disable iff (!nrst)
    s_modeCWrite |=> (modeC_reg == $past(pwdata[3:0], 2)))
    else $error("timer C mode did not settle two cycles after write");

  a_high_load_b: assert property (@(posedge clk) disable iff (!nrst)
    wrBHi |=> (cntB_reg == reloadB_reg) && (cntB_reg[7:4] == $past(pwdata[3:0])))
    else $error("high digit write did not load timer B");

  a_capture_low: assert property (@(posedge clk) disable iff (!nrst)
    rdBHi ##1 (access && hitBHi) ##1 !rdBHi ##1 (setup && !pwrite && hitBLo && !rdBHi)
    |=> (prdata[3:0] == $past(cntB_reg[3:0], 4)))
    else $error("low digit read did not return captured value");

  a_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    (tickA && !subHold && cntA_reg == COUNT_TOP) |=> (cntA_reg == COUNT_RST) && ovf.a)
    else $error("timer A did not wrap with overflow");

  a_restart_b: assert property (@(posedge clk) disable iff (!nrst)
    (wrapB && !wrBHi) |=> ovf.b && (cntB_reg == $past(restartB)))
    else $error("timer B overflow restart wrong");

  a_hold_reset: assert property (@(posedge clk) disable iff (!nrst)
    subHold [*2] |-> (cntA_reg == COUNT_RST) && (subPsc_reg == '0) && lcdPowerOff)
    else $error("time base reset code did not hold timer A");

  a_pwm_settle: assert property (@(posedge clk) disable iff (!nrst)
    (wrCHi && !wrapC) ##1 !wrapC |-> $stable(pwmRef_reg))
    else $error("pwm reference moved before overflow");

  a_interval_rate: assert property (@(posedge clk) disable iff (!nrst)
    (!timeBase && codeA == 3'h7 && $stable(modeA_reg) && tickA) |=> !tickA)
    else $error("fastest interval tick not every second cycle");

endmodule : ttm_timers

/* sim/tb.sv */
`timescale 1ns/1ps

module tb;
  import ttm_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk, nrst, psel, penable, pwrite, pready, pslverr; // Clock, reset, APB
  logic [5:0] paddr; // Byte address
  logic [31:0] pwdata, prdata; // APB data
  logic subTick, evtInN, pwmOut, lcdPowerOff; // Timer pins
  ttm_ovf_t ovf; // Overflow pulses: a is bit 2, b bit 1, c bit 0
  int errors, nTests, subCnt, ovfBCnt;
  localparam logic [5:0] AD_MA = {IDX_MODE_A, 2'b00};
  localparam logic [5:0] AD_MB = {IDX_MODE_B, 2'b00};
  localparam logic [5:0] AD_BL = {IDX_DIG_B_LO, 2'b00};
  localparam logic [5:0] AD_BH = {IDX_DIG_B_HI, 2'b00};
  localparam logic [5:0] AD_MC = {IDX_MODE_C, 2'b00};
  localparam logic [5:0] AD_CL = {IDX_DIG_C_LO, 2'b00};
  localparam logic [5:0] AD_CH = {IDX_DIG_C_HI, 2'b00};

  ttm_timers #(.ADDR_W(6)) dut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subTick(subTick), .evtInN(evtInN), .ovf(ovf), .pwmOut(pwmOut),
    .lcdPowerOff(lcdPowerOff));

  // ==========================================================================
  // Clock, half sub-cycle ticks every 4 clocks, overflow counter of timer B
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    subCnt <= (subCnt + 1) % 4;
    subTick <= (subCnt == 3);
    if (ovf.b === 1'b1) ovfBCnt <= ovfBCnt + 1;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [5:0] a, input logic [3:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {28'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t no ready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (3) @(posedge clk); // Lets a mode write settle before anything follows
  endtask : wr

  // Low digit first, high digit second
  task automatic load(input logic [5:0] lo, input logic [5:0] hi, input logic [7:0] v);
    wr(lo, v[3:0]);
    wr(hi, v[7:4]);
  endtask : load

  // High digit first, then the captured low digit
  task automatic rdCnt(input logic [5:0] lo, input logic [5:0] hi, output logic [7:0] v);
    logic [31:0] h, l;
    logic e;
    apb(1'b0, hi, 4'h0, h, e);
    apb(1'b0, lo, 4'h0, l, e);
    v = {h[3:0], l[3:0]};
  endtask : rdCnt

  // One falling edge on the event input, then time to pass the synchroniser
  task automatic evtEdge();
    evtInN <= 1'b0;
    repeat (3) @(posedge clk);
    evtInN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : evtEdge

  // Waits one overflow pulse, then counts clocks to the next one
  task automatic period(input int idx, output int per);
    int n;
    n = 0;
    while (ovf[idx] !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    per = 1;
    while (ovf[idx] !== 1'b1 && per < 20000) begin
      @(posedge clk);
      per++;
    end
  endtask : period

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, {24'h0, COUNT_RST}, "B count after reset");
    rdCnt(AD_CL, AD_CH, v);
    check({24'h0, v}, {24'h0, COUNT_RST}, "C count after reset");
    apb(1'b0, 6'h00, 4'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped slverr");
    check(r, 32'h0, "unmapped read");
    wr(AD_MB, 4'h7);
    apb(1'b0, AD_MB, 4'h0, r, e);
    check(r, 32'h0, "mode write-only read");
    wr(AD_BH, 4'hF);
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, 32'hF0, "high write uses reset low");
    $display("Test reset done");
  endtask : t_reset

  task automatic t_digits();
    logic [31:0] h, l;
    logic e;
    logic [7:0] v;
    load(AD_BL, AD_BH, 8'h5A);
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, 32'h5A, "B load and read");
    load(AD_BL, AD_BH, 8'h0F);
    apb(1'b0, AD_BH, 4'h0, h, e);
    evtEdge();
    apb(1'b0, AD_BL, 4'h0, l, e);
    check({h[7:0], l[7:0]}, 32'h000F, "low digit captured at high read");
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, 32'h10, "one event one count");
    $display("Test digits done");
  endtask : t_digits

  task automatic t_reloadB();
    logic [7:0] v;
    int c0;
    wr(AD_MB, 4'hF);
    load(AD_BL, AD_BH, 8'hFE);
    c0 = ovfBCnt;
    evtEdge();
    evtEdge();
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, 32'hFE, "B auto reload");
    check(ovfBCnt - c0, 1, "B one overflow pulse");
    wr(AD_MB, 4'h7);
    evtEdge();
    evtEdge();
    rdCnt(AD_BL, AD_BH, v);
    check({24'h0, v}, 32'h00, "B wrap to zero");
    $display("Test reload B done");
  endtask : t_reloadB

  task automatic t_ratios();
    int per;
    int ra[3] = '{2, 4, 8};
    int rb[2] = '{2, 4};
    int rc[3] = '{2, 4, 8};
    for (int i = 0; i < 3; i++) begin
      wr(AD_MA, 4'(7 - i));
      period(2, per);
      check(per, ra[i] * 256, "timer A interval period");
    end
    for (int i = 0; i < 2; i++) begin
      wr(AD_MB, 4'(6 - i));
      period(1, per);
      check(per, rb[i] * 256, "timer B period");
    end
    for (int i = 0; i < 3; i++) begin
      wr(AD_MC, 4'(7 - i));
      period(0, per);
      check(per, rc[i] * 256, "timer C period");
    end
    wr(AD_MC, 4'hF);
    load(AD_CL, AD_CH, 8'hF0);
    period(0, per);
    check(per, 32, "timer C reload period");
    wr(AD_MC, 4'h7);
    period(0, per);
    period(0, per);
    check(per, 512, "timer C free run period");
    repeat (2) @(posedge clk);
    check({31'h0, pwmOut}, 32'h0, "pwm low below reference");
    repeat (498) @(posedge clk);
    check({31'h0, pwmOut}, 32'h1, "pwm high from reference");
    $display("Test ratios done");
  endtask : t_ratios

  task automatic t_timebase();
    int per;
    wr(AD_MA, 4'hE);
    check({31'h0, lcdPowerOff}, 32'h1, "sub prescaler reset powers LCD off");
    wr(AD_MA, 4'hC);
    check({31'h0, lcdPowerOff}, 32'h0, "LCD power back");
    period(2, per);
    check(per, 1024, "time base half sub-cycle");
    wr(AD_MA, 4'hE);
    wr(AD_MA, 4'hB);
    period(2, per);
    check(per, 4096, "time base two sub-cycles");
    $display("Test time base done");
  endtask : t_timebase

  // ==========================================================================
  // Verdict, watchdog and main sequence
  // ==========================================================================
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // Longest run is about 30000 clocks; over twice that means a hang
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 6'h00;
    pwdata = 32'h0; evtInN = 1'b1; subTick = 1'b0; subCnt = 0; ovfBCnt = 0;
    errors = 0; nTests = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_digits();
    t_reloadB();
    t_ratios();
    t_timebase();
    final_report();
  end
endmodule : tb
